// ==== dv/pll_clock_source_select_tb.sv ====
// Self-checking bench for clock source selection and phase sequencing
`default_nettype none
module pll_clock_source_select_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       ref_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       strap = 1'b0;
    logic       run = 1'b0;
    logic [2:0] ext_half = 3'h2;
    logic [2:0] osc_half = 3'h2;
    logic       ext_clock_in, pll_osc_in, pll_enable_bit, pll_power_en;
    logic       pll_ref_out, cycle_start, strap_kept, prev_src;
    logic [1:0] core_phase;
    int         edge_cnt;
    int         error_cnt = 0;
    int         check_count = 0;
    int         seed = 32'hf9fa;
    always #5 ref_clk = ~ref_clk;
    pllcs_src_model partner (.ref_clk(ref_clk), .run(run), .ext_half(ext_half),
        .osc_half(osc_half), .ext_clock_in(ext_clock_in), .pll_osc_in(pll_osc_in));
    pllcs_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .ext_clock_in(ext_clock_in),
        .pll_init_strap(strap), .pll_osc_in(pll_osc_in), .pll_enable_bit(pll_enable_bit),
        .pll_power_en(pll_power_en), .pll_ref_out(pll_ref_out),
        .core_phase(core_phase), .cycle_start(cycle_start));
    task automatic check(input string what, input logic [1:0] exp, input logic [1:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Every source level change is one phase; a cycle starts when the count wraps
    function automatic logic [1:0] exp_phase(input int edges);
        return 2'(edges % pllcs_pkg::PHASE_COUNT);
    endfunction
    function automatic logic exp_start(input logic hit, input int edges);
        return hit && (edges % pllcs_pkg::PHASE_COUNT == 0);
    endfunction
    // Counts selected-source changes as sampled at each edge, so the check is latency-free
    task automatic step(input logic nrst, input logic nrun, input logic nstrap);
        logic       r;
        logic       e;
        logic       hit;
        r = rst_n;
        e = ext_clock_in;
        hit = 1'b0;
        if (!r) begin
            strap_kept = strap;
            prev_src = 1'b0;
            edge_cnt = 0;
        end else if ((strap_kept ? pll_osc_in : ext_clock_in) !== prev_src) begin
            prev_src = ~prev_src;
            edge_cnt++;
            hit = 1'b1;
        end
        @(posedge ref_clk);
        rst_n <= nrst;
        run <= nrun;
        strap <= nstrap;
        if (!nrst) begin
            ext_half <= 3'h2 + 3'($unsigned($random(seed)) % 4);
            osc_half <= 3'h2 + 3'($unsigned($random(seed)) % 2);
        end
        #1;
        if (!r) begin
            check("enable", {1'b0, strap_kept}, {1'b0, pll_enable_bit});
            check("reset phase", 2'h0, core_phase);
            check("reset power", 2'h0, {pll_power_en, pll_ref_out});
        end else begin
            check("enable hold", {1'b0, strap_kept}, {1'b0, pll_enable_bit});
            check("power", {1'b0, strap_kept}, {1'b0, pll_power_en});
            check("ref", {1'b0, strap_kept & e}, {1'b0, pll_ref_out});
            check("step", exp_phase(edge_cnt), core_phase);
            check("start", {1'b0, exp_start(hit, edge_cnt)}, {1'b0, cycle_start});
        end
    endtask
    task automatic give_verdict();
        if (error_cnt == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        for (int i = 0; i < 6; i++) begin
            repeat (6) step(1'b0, 1'b1, (i < 2) ? i[0] : 1'($random(seed)));
            repeat (300) step(1'b1, 1'b1, 1'($random(seed)));
            repeat (4) step(1'b1, 1'b0, 1'($random(seed)));
            check("phase", exp_phase(edge_cnt), core_phase);
        end
        give_verdict();
    end
endmodule
`default_nettype wire

// ==== dv/pllcs_src_model.sv ====
// Behavioural external clock source and PLL oscillator for the bench
`default_nettype none
module pllcs_src_model (
    input  wire logic       ref_clk,
    input  wire logic       run,
    input  wire logic [2:0] ext_half,
    input  wire logic [2:0] osc_half,
    output var logic        ext_clock_in,
    output var logic        pll_osc_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] ext_cnt = 3'h1;
    logic [2:0] osc_cnt = 3'h1;
    initial ext_clock_in = 1'b0;
    initial pll_osc_in = 1'b0;
    // Both sources stand still while run is low, so the phase settles for a final check
    always @(posedge ref_clk) if (run) begin
        ext_cnt <= (ext_cnt >= ext_half) ? 3'h1 : ext_cnt + 3'h1;
        osc_cnt <= (osc_cnt >= osc_half) ? 3'h1 : osc_cnt + 3'h1;
        if (ext_cnt >= ext_half) ext_clock_in <= ~ext_clock_in;
        if (osc_cnt >= osc_half) pll_osc_in <= ~pll_osc_in;
    end
endmodule
`default_nettype wire

// ==== hdl/pllcs_edge_det.sv ====
// Edge detector that turns the selected source level into one-cycle strobes
`default_nettype none
module pllcs_edge_det (
    input  wire logic   ref_clk,
    input  wire logic   rst_n,
    pllcs_src_if.detect src
);
    logic prev;
    logic next_prev;

    always_comb begin
        if (!rst_n) begin
            next_prev = pllcs_pkg::RST_EDGE_PREV;
        end else begin
            next_prev = src.src_level;
        end
    end

    always_ff @(posedge ref_clk) begin
        prev <= next_prev;
    end

    // Both edges count: each half period of the source is one phase
    // A source already high at release reads as one edge, so the first phase may be skipped
    assign src.src_edge = rst_n && (src.src_level != prev);
endmodule
`default_nettype wire

// ==== hdl/pllcs_pkg.sv ====
// Package of constants and types for the clock source select block
`default_nettype none
package pllcs_pkg;
    // Selected source is divided by this ratio to form one instruction cycle
    localparam int unsigned DIV_RATIO = 2;
    // One instruction cycle holds two source periods, so four source edges
    localparam int unsigned PHASE_COUNT = 2 * DIV_RATIO;
    localparam int unsigned PHASE_W = $clog2(PHASE_COUNT);
    localparam logic RST_PLL_POWER = 1'b0;
    localparam logic RST_PLL_REF = 1'b0;
    localparam logic RST_CYCLE_START = 1'b0;
    localparam logic RST_EDGE_PREV = 1'b0;

    typedef enum logic [1:0] {
        PLLCS_PH0 = 2'b00,
        PLLCS_PH1 = 2'b01,
        PLLCS_PH2 = 2'b10,
        PLLCS_PH3 = 2'b11
    } pllcs_phase_t;
endpackage
`default_nettype wire

// ==== hdl/pllcs_src_if.sv ====
// Interface carrying the selected clock source level and its edge strobe
`default_nettype none
interface pllcs_src_if;
    logic src_level;
    logic src_edge;

    modport detect (
        input  src_level,
        output src_edge
    );
    modport use_src (
        output src_level,
        input  src_edge
    );
endinterface
`default_nettype wire

// ==== hdl/pllcs_top.sv ====
// Clock source selection and four-phase instruction cycle sequencer
`default_nettype none
module pllcs_top (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        ext_clock_in,
    input  wire logic        pll_init_strap,
    input  wire logic        pll_osc_in,
    output logic             pll_enable_bit,
    output logic             pll_power_en,
    output logic             pll_ref_out,
    output logic [1:0]       core_phase,
    output logic             cycle_start
);
    pllcs_src_if src_bus ();

    pllcs_pkg::pllcs_phase_t phase;
    pllcs_pkg::pllcs_phase_t next_phase;
    logic                    next_enable;
    logic                    next_power;
    logic                    next_ref;
    logic                    next_cycle_start;
    // Source edges since the last cycle start; read only by the checks below
    logic [2:0]              edge_tally;
    logic [2:0]              next_edge_tally;

    // Strap is taken on every reset edge, so the last edge before release wins
    always_comb begin
        if (!rst_n) begin
            next_enable = pll_init_strap;
        end else begin
            next_enable = pll_enable_bit;
        end
    end

    always_ff @(posedge ref_clk) begin
        pll_enable_bit <= next_enable;
    end

    // The PLL analog loop sits outside; it multiplies the routed reference
    always_comb begin
        if (!rst_n) begin
            next_power = pllcs_pkg::RST_PLL_POWER;
            next_ref = pllcs_pkg::RST_PLL_REF;
        end else begin
            next_power = pll_enable_bit;
            next_ref = pll_enable_bit && ext_clock_in;
        end
    end

    always_ff @(posedge ref_clk) begin
        pll_power_en <= next_power;
        pll_ref_out <= next_ref;
    end

    // Choosing the source picks which level feeds the edge detector
    assign src_bus.src_level = pll_enable_bit ? pll_osc_in : ext_clock_in;

    pllcs_edge_det u_edge (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .src     (src_bus.detect)
    );

    // Successor of a phase; the wrap back to the first phase marks a new cycle
    function automatic pllcs_pkg::pllcs_phase_t phase_after(
        input pllcs_pkg::pllcs_phase_t cur
    );
        pllcs_pkg::pllcs_phase_t nxt;
        case (cur)
            pllcs_pkg::PLLCS_PH0: nxt = pllcs_pkg::PLLCS_PH1;
            pllcs_pkg::PLLCS_PH1: nxt = pllcs_pkg::PLLCS_PH2;
            pllcs_pkg::PLLCS_PH2: nxt = pllcs_pkg::PLLCS_PH3;
            pllcs_pkg::PLLCS_PH3: nxt = pllcs_pkg::PLLCS_PH0;
            default: nxt = pllcs_pkg::PLLCS_PH0;
        endcase
        return nxt;
    endfunction

    // Each source edge is one phase: four phases span two source periods
    always_comb begin
        next_phase = phase;
        next_cycle_start = 1'b0;
        if (src_bus.src_edge) begin
            next_phase = phase_after(phase);
            next_cycle_start = (phase_after(phase) == pllcs_pkg::PLLCS_PH0);
        end
        if (!rst_n) begin
            next_phase = pllcs_pkg::PLLCS_PH0;
            next_cycle_start = pllcs_pkg::RST_CYCLE_START;
        end
    end

    always_ff @(posedge ref_clk) begin
        phase <= next_phase;
        cycle_start <= next_cycle_start;
    end

    // Saturates, so a missed wrap shows as a bound failure rather than a silent roll-over
    always_comb begin
        next_edge_tally = cycle_start ? 3'h0 : edge_tally;
        if (src_bus.src_edge && next_edge_tally != 3'h7) begin
            next_edge_tally = 3'(next_edge_tally + 3'h1);
        end
        if (!rst_n) begin
            next_edge_tally = 3'h0;
        end
    end

    always_ff @(posedge ref_clk) begin
        edge_tally <= next_edge_tally;
    end

    // Phase goes only to the core; no lock flag or clock pin exists
    assign core_phase = phase;

    strap_copy_a: assert property (@(posedge ref_clk)
        !rst_n |=> pll_enable_bit == $past(pll_init_strap))
        else $error("enable bit did not take strap during reset");

    strap_ignore_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $past(rst_n) |-> $stable(pll_enable_bit))
        else $error("enable bit changed after reset release");

    pll_source_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pll_enable_bit && $changed(pll_osc_in) && $past(rst_n)
            |=> core_phase == 2'($past(core_phase) + 2'h1))
        else $error("PLL edge did not advance phase");

    ext_source_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !pll_enable_bit && $changed(ext_clock_in) && $past(rst_n)
            |=> core_phase == 2'($past(core_phase) + 2'h1))
        else $error("external edge did not advance phase");

    pll_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !pll_enable_bit && $past(rst_n) |=> !pll_power_en && !pll_ref_out)
        else $error("PLL not held off while disabled");

    ref_route_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pll_enable_bit |=> pll_power_en && pll_ref_out == $past(ext_clock_in))
        else $error("external clock not routed to PLL");

    phase_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !src_bus.src_edge |=> $stable(core_phase))
        else $error("phase moved without a source edge");

    cycle_wrap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        src_bus.src_edge && core_phase == 2'h3
            |=> cycle_start && core_phase == 2'h0 ##1 !cycle_start)
        else $error("instruction cycle wrap wrong");

    phase_clear_a: assert property (@(posedge ref_clk)
        !rst_n |=> core_phase == 2'h0 && !cycle_start)
        else $error("phase not cleared by reset");

    phase_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        src_bus.src_edge
            |=> core_phase == 2'($past(core_phase) + 2'h1))
        else $error("source edge did not advance phase");

    // The unselected source may toggle freely; only the chosen one moves the phase
    ext_ignored_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pll_enable_bit && !$changed(pll_osc_in) && $past(rst_n)
            |=> $stable(core_phase))
        else $error("phase moved on an unselected external edge");

    osc_ignored_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !pll_enable_bit && !$changed(ext_clock_in) && $past(rst_n)
            |=> $stable(core_phase))
        else $error("phase moved on an unselected oscillator edge");

    power_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $past(rst_n)
            |-> pll_power_en == $past(pll_enable_bit))
        else $error("PLL power does not follow the enable bit");

    // Strap changes after release must never reach the PLL controls
    power_steady_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $past(rst_n) && $past(rst_n, 2)
            |-> $stable(pll_power_en))
        else $error("PLL power changed after reset release");

    ctl_reset_a: assert property (@(posedge ref_clk)
        !rst_n |=> !pll_power_en && !pll_ref_out)
        else $error("PLL controls not cleared by reset");

    start_phase_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cycle_start |-> core_phase == 2'h0)
        else $error("cycle start outside the first phase");

    single_start_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cycle_start |=> !cycle_start)
        else $error("cycle start longer than one cycle");

    start_cause_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cycle_start
            |-> $past(src_bus.src_edge) && $past(core_phase) == 2'h3)
        else $error("cycle start without a wrapping source edge");

    cycle_length_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cycle_start
            |-> edge_tally == 3'(pllcs_pkg::PHASE_COUNT))
        else $error("instruction cycle not four source edges long");

    tally_bound_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        edge_tally <= 3'(pllcs_pkg::PHASE_COUNT))
        else $error("more than four source edges without a cycle start");

    ref_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pll_ref_out |-> pll_power_en)
        else $error("reference driven while PLL powered down");
endmodule
`default_nettype wire
